// >>> sdcb_burst_addr.sv
/*
 Burst column generator: column of a given beat from the start column,
 the programmed burst length and the burst order.
 Assumes pure combinational use by the burst engine.
*/
`timescale 1ns/1ps
module sdcb_burst_addr (
   input logic [sdcb_pkg::COL_W-1:0] start_col,
   input logic [sdcb_pkg::COL_W-1:0] beat,
   input logic [2:0] burst_len,
   input logic interleave,
   output logic [sdcb_pkg::COL_W-1:0] col,
   output logic [sdcb_pkg::COL_W-1:0] mask
);
   import sdcb_pkg::*;

   logic [COL_W-1:0] moved; // Low bits after stepping

   always_comb begin
      case (burst_len)
         BL_1, BL_2, BL_4, BL_8: mask = COL_W'((COL_W'(1) << burst_len) - COL_W'(1));
         // Full page walks the whole row and wraps at its end
         BL_PAGE: mask = '1;
         // Undefined codes behave as single beats
         default: mask = '0;
      endcase
   end

   always_comb begin
      if (interleave && burst_len != BL_PAGE) begin
         moved = start_col ^ beat;
      end else begin
         moved = COL_W'(start_col + beat);
      end
      col = (start_col & ~mask) | (moved & mask);
   end
endmodule

// >>> sdcb_core.sv
/*
 SDRAM command decode, bank row tracking and burst read/write engine,
 as it sits behind the memory pins. Holds the mode register, the open
 row of each bank, the burst sequencer, the read output pipeline and a
 write buffer towards the storage array.
 Assumes the pins are driven synchronously to mclk by the controller,
 a storage array with one-cycle synchronous read, and a testbench that
 resolves the data wire from dq_oe.
*/
`timescale 1ns/1ps
module sdcb_core (
   input logic mclk,
   input logic reset_n,
   input logic cke,
   input logic cs_n,
   input logic ras_n,
   input logic cas_n,
   input logic we_n,
   input logic [sdcb_pkg::BANK_W-1:0] ba,
   input logic [sdcb_pkg::ADDR_W-1:0] addr,
   input logic [sdcb_pkg::MASK_W-1:0] dqm,
   input logic [sdcb_pkg::DATA_W-1:0] dq_in,
   output logic [sdcb_pkg::DATA_W-1:0] dq_out,
   output logic [sdcb_pkg::MASK_W-1:0] dq_oe,
   output logic mem_rd_en,
   output logic [sdcb_pkg::BANK_W-1:0] mem_rd_bank,
   output logic [sdcb_pkg::ADDR_W-1:0] mem_rd_row,
   output logic [sdcb_pkg::COL_W-1:0] mem_rd_col,
   input logic [sdcb_pkg::DATA_W-1:0] mem_rd_data,
   output logic mem_wr_valid,
   input logic mem_wr_ready,
   output logic [sdcb_pkg::BANK_W-1:0] mem_wr_bank,
   output logic [sdcb_pkg::ADDR_W-1:0] mem_wr_row,
   output logic [sdcb_pkg::COL_W-1:0] mem_wr_col,
   output logic [sdcb_pkg::MASK_W-1:0] mem_wr_mask,
   output logic [sdcb_pkg::DATA_W-1:0] mem_wr_data,
   output logic write_buf_ready
);
   import sdcb_pkg::*;

   // Clock enable seen at the previous edge
   logic cke_q;
   // Mode register fields
   logic [2:0] mr_len;
   logic mr_bt;
   logic [2:0] mr_cl;
   logic [2:0] next_mr_len;
   logic next_mr_bt;
   logic [2:0] next_mr_cl;
   // Bank state: open flag and open row
   logic [NUM_BANKS-1:0] bank_active;
   logic [ADDR_W-1:0] open_row [NUM_BANKS];
   logic [NUM_BANKS-1:0] next_bank_active;
   logic [ADDR_W-1:0] next_open_row [NUM_BANKS];
   // Burst engine
   sdcb_state_type state;
   sdcb_state_type next_state;
   logic [BANK_W-1:0] burst_bank;
   logic [ADDR_W-1:0] burst_row;
   logic [COL_W-1:0] burst_start;
   logic [COL_W-1:0] burst_beat;
   logic [BANK_W-1:0] next_burst_bank;
   logic [ADDR_W-1:0] next_burst_row;
   logic [COL_W-1:0] next_burst_start;
   logic [COL_W-1:0] next_burst_beat;
   // Read output pipeline
   logic rd_valid_q; // Storage data valid this cycle
   logic stage_valid; // Extra stage for latency three
   logic [DATA_W-1:0] stage_data;
   logic [MASK_W-1:0] dqm_q; // Read mask, first of two delays
   logic next_out_valid;
   logic [DATA_W-1:0] next_dq_out;
   logic [MASK_W-1:0] next_dq_oe;
   // Decoded commands
   logic cmd_sel;
   logic [2:0] cmd;
   logic is_mrs;
   logic is_act;
   logic is_pre;
   logic is_read;
   logic is_write;
   logic is_stop;
   logic col_cmd;
   logic cl2;
   // Current beat
   logic [BANK_W-1:0] acc_bank;
   logic [ADDR_W-1:0] acc_row;
   logic [COL_W-1:0] gen_start;
   logic [COL_W-1:0] gen_beat;
   logic [COL_W-1:0] cur_col;
   logic [COL_W-1:0] len_mask;
   logic wr_beat;
   logic fifo_in_valid;
   logic [WR_WORD_W-1:0] fifo_in_data;
   logic [WR_WORD_W-1:0] fifo_out_data;

   // Command decode, gated by chip select and clock enable
   assign cmd_sel = cke_q && !cs_n;
   assign cmd = {ras_n, cas_n, we_n};
   assign is_mrs = cmd_sel && (cmd == CMD_MRS);
   assign is_act = cmd_sel && (cmd == CMD_ACT);
   assign is_pre = cmd_sel && (cmd == CMD_PRE);
   assign is_read = cmd_sel && (cmd == CMD_READ);
   assign is_write = cmd_sel && (cmd == CMD_WRITE);
   assign is_stop = cmd_sel && (cmd == CMD_STOP);
   assign col_cmd = is_read || is_write;
   assign cl2 = (mr_cl == CL_2);

   // First beat comes straight from the pins, later ones from the engine
   assign gen_start = col_cmd ? addr[COL_W-1:0] : burst_start;
   assign gen_beat = col_cmd ? '0 : burst_beat;
   assign acc_bank = col_cmd ? ba : burst_bank;
   assign acc_row = col_cmd ? open_row[ba] : burst_row;

   sdcb_burst_addr u_burst_addr (
      .start_col(gen_start),
      .beat(gen_beat),
      .burst_len(mr_len),
      .interleave(mr_bt),
      .col(cur_col),
      .mask(len_mask)
   );

   assign mem_rd_en = is_read || (state == ST_READ && !is_write && !is_stop);
   assign mem_rd_bank = acc_bank;
   assign mem_rd_row = acc_row;
   assign mem_rd_col = cur_col;

   assign wr_beat = is_write || (state == ST_WRITE && !is_read && !is_stop);
   assign fifo_in_valid = wr_beat && (dqm != '1);
   assign fifo_in_data = {acc_bank, acc_row, cur_col, ~dqm, dq_in};

   // Buffer decouples the pins from a storage array that may stall;
   // the pins cannot be held off, so a full buffer drops the beat
   sdcb_fifo #(
      .WIDTH(WR_WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .mclk(mclk),
      .reset_n(reset_n),
      .in_valid(fifo_in_valid),
      .in_ready(write_buf_ready),
      .in_data(fifo_in_data),
      .out_valid(mem_wr_valid),
      .out_ready(mem_wr_ready),
      .out_data(fifo_out_data)
   );
   assign {mem_wr_bank, mem_wr_row, mem_wr_col, mem_wr_mask, mem_wr_data} = fifo_out_data;

   // Mode register next value
   always_comb begin
      next_mr_len = mr_len;
      next_mr_bt = mr_bt;
      next_mr_cl = mr_cl;
      if (is_mrs) begin
         next_mr_len = addr[MR_BL_LSB +: MR_BL_W];
         next_mr_bt = addr[MR_BT_BIT];
         next_mr_cl = addr[MR_CL_LSB +: MR_CL_W];
      end
   end

   // Bank open rows; activation spacing is the controller's business
   always_comb begin
      next_bank_active = bank_active;
      next_open_row = open_row;
      if (is_act) begin
         next_bank_active[ba] = 1'b1;
         next_open_row[ba] = addr;
      end else if (is_pre) begin
         if (addr[PRE_ALL_BIT]) begin
            next_bank_active = '0;
         end else begin
            next_bank_active[ba] = 1'b0;
         end
      end
   end

   // Burst sequencer
   always_comb begin
      next_state = state;
      next_burst_bank = burst_bank;
      next_burst_row = burst_row;
      next_burst_start = burst_start;
      next_burst_beat = burst_beat;
      if (col_cmd) begin
         next_burst_bank = ba;
         next_burst_row = open_row[ba];
         next_burst_start = addr[COL_W-1:0];
         next_burst_beat = COL_W'(1);
         if (len_mask == '0) begin
            next_state = ST_IDLE;
         end else if (is_read) begin
            next_state = ST_READ;
         end else begin
            next_state = ST_WRITE;
         end
      end else if (is_stop) begin
         next_state = ST_IDLE;
      end else if (state != ST_IDLE) begin
         if (mr_len != BL_PAGE && burst_beat == len_mask) begin
            next_state = ST_IDLE;
         end else begin
            next_burst_beat = COL_W'(burst_beat + 1'b1);
         end
      end
   end

   // Read output path; storage answers one cycle after the strobe
   always_comb begin
      next_out_valid = cl2 ? rd_valid_q : stage_valid;
      next_dq_out = cl2 ? mem_rd_data : stage_data;
      next_dq_oe = {MASK_W{next_out_valid}} & ~dqm_q;
   end

   // Mode, bank and burst registers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cke_q <= 1'b0;
         mr_len <= MR_BL_RESET;
         mr_bt <= MR_BT_RESET;
         mr_cl <= MR_CL_RESET;
         bank_active <= '0;
         for (int i = 0; i < NUM_BANKS; i++) begin
            open_row[i] <= '0;
         end
         state <= ST_IDLE;
         burst_bank <= '0;
         burst_row <= '0;
         burst_start <= '0;
         burst_beat <= '0;
      end else begin
         cke_q <= cke;
         mr_len <= next_mr_len;
         mr_bt <= next_mr_bt;
         mr_cl <= next_mr_cl;
         bank_active <= next_bank_active;
         open_row <= next_open_row;
         state <= next_state;
         burst_bank <= next_burst_bank;
         burst_row <= next_burst_row;
         burst_start <= next_burst_start;
         burst_beat <= next_burst_beat;
      end
   end

   // Read pipeline registers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rd_valid_q <= 1'b0;
         stage_valid <= 1'b0;
         stage_data <= '0;
         dqm_q <= '0;
         dq_out <= '0;
         dq_oe <= '0;
      end else begin
         rd_valid_q <= mem_rd_en;
         stage_valid <= rd_valid_q;
         stage_data <= mem_rd_data;
         dqm_q <= dqm;
         dq_out <= next_dq_out;
         dq_oe <= next_dq_oe;
      end
   end

   // Checks on the decode and the burst engine
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   sequence s_issue_cl2;
      mem_rd_en && cl2 ##1 cl2;
   endsequence

   sequence s_stop_read;
      is_stop && state == ST_READ;
   endsequence

   a_mrs_load:
   assert property (is_mrs |=> mr_len == $past(addr[MR_BL_LSB +: MR_BL_W])
      && mr_cl == $past(addr[MR_CL_LSB +: MR_CL_W]))
      else $error("mode register did not load");

   a_read_decode:
   assert property (cmd_sel && {ras_n, cas_n, we_n} == 3'h5 |->
      mem_rd_en && mem_rd_bank == ba && mem_rd_col == addr[COL_W-1:0])
      else $error("read command not started");

   a_write_decode:
   assert property (cmd_sel && {ras_n, cas_n, we_n} == 3'h4 && dqm == '0 |->
      fifo_in_valid && fifo_in_data[DATA_W +: MASK_W] == '1)
      else $error("write first datum not taken");

   a_read_back:
   assert property (is_read ##1 is_read |-> mem_rd_en && mem_rd_col == addr[COL_W-1:0])
      else $error("back to back read not accepted");

   a_read_data:
   assert property (s_issue_cl2 |=> dq_out == $past(mem_rd_data))
      else $error("read data not on pins after latency");

   a_stop_cl2:
   assert property (s_stop_read ##0 cl2 |-> ##2 dq_oe == '0)
      else $error("stopped read still driving");

   a_stop_cl3:
   assert property (s_stop_read ##0 mr_cl == CL_3 ##1 mr_cl == CL_3 |-> ##2 dq_oe == '0)
      else $error("stopped read still driving");

   a_stop_row:
   assert property (is_stop |=> state == ST_IDLE && bank_active == $past(bank_active))
      else $error("burst stop misbehaved");

   a_write_idle:
   assert property (state == ST_IDLE && !is_write |-> !fifo_in_valid)
      else $error("write data taken outside burst");

   a_read_cuts:
   assert property (state == ST_WRITE && is_read |-> !fifo_in_valid ##1 state != ST_WRITE)
      else $error("read did not end write");

   a_write_restart:
   assert property (state == ST_WRITE && is_write && mr_len != BL_1 |=>
      state == ST_WRITE && burst_beat == COL_W'(1) && burst_start == $past(addr[COL_W-1:0]))
      else $error("write did not restart burst");

   a_seq_wrap:
   assert property (state == ST_READ && !mr_bt && mr_len == BL_4 && mem_rd_en && !is_read |->
      mem_rd_col[COL_W-1:2] == burst_start[COL_W-1:2])
      else $error("sequential burst carried past low bits");

   a_page_run:
   assert property (state != ST_IDLE && mr_len == BL_PAGE && !col_cmd && !is_stop |=>
      state == $past(state))
      else $error("full page burst ended by itself");

   a_mask_read:
   assert property (dqm[0] |-> ##2 !dq_oe[0])
      else $error("read mask latency wrong");
endmodule

// >>> sdcb_core_test.sv
/*
 Bench of the command and burst logic: plays the memory controller on
 the pins, mirrors storage and checks read beats and lane enables by step.
 Assumes the storage model's start pattern and the package constants.
*/
`timescale 1ns/1ps
module sdcb_core_test;
   import sdcb_pkg::*;
   localparam logic [2:0] NOP = 3'h7; // No-operation code
   logic mclk, reset_n, cke, cs_n, ras_n, cas_n, we_n, stall, hold;
   logic mem_rd_en, mem_wr_valid, mem_wr_ready, write_buf_ready;
   logic [1:0] ba, dqm, dq_oe, mem_rd_bank, mem_wr_bank, mem_wr_mask;
   logic [12:0] addr, mem_rd_row, mem_wr_row;
   logic [8:0] mem_rd_col, mem_wr_col, s;
   logic [15:0] dq_in, dq_out, mem_rd_data, mem_wr_data, seed;
   logic [15:0] mir [0:3][0:511]; // Storage mirror
   logic [15:0] e_d [int]; // Expected word by step
   logic [1:0] e_oe [int]; // Expected lane enables by step
   logic [2:0] g_bl; // Programmed length code
   logic g_il; // Programmed order
   logic [12:0] g_row [0:3]; // Row opened in each bank
   int g_cl, cyc, keep, fails, tests_run;

   sdcb_core dut (.mclk, .reset_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
      .dqm, .dq_in, .dq_out, .dq_oe, .mem_rd_en, .mem_rd_bank, .mem_rd_row,
      .mem_rd_col, .mem_rd_data, .mem_wr_valid, .mem_wr_ready, .mem_wr_bank,
      .mem_wr_row, .mem_wr_col, .mem_wr_mask, .mem_wr_data, .write_buf_ready);
   sdcb_store_model store (.mclk, .mem_rd_en, .mem_rd_bank, .mem_rd_col,
      .mem_rd_data, .mem_wr_valid, .mem_wr_ready, .mem_wr_bank, .mem_wr_col,
      .mem_wr_mask, .mem_wr_data, .stall);

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   // Column of beat k; full page wraps the whole row
   function automatic logic [8:0] bcol(input logic [8:0] st, input int k);
      logic [8:0] m;
      m = (g_bl == BL_PAGE) ? 9'h1ff : 9'((1 << g_bl) - 1);
      return (st & ~m) | (((g_il && g_bl != BL_PAGE) ? st ^ 9'(k) : st + 9'(k)) & m);
   endfunction
   task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic summarize();
      if (fails == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // One bus cycle: check what is due, then drive the pins once
   task automatic step(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
      input logic [15:0] d, input logic [1:0] m);
      logic [15:0] lm;
      @(negedge mclk);
      cyc++;
      if (e_oe.exists(cyc)) begin
         lm = {{8{e_oe[cyc][1]}}, {8{e_oe[cyc][0]}}};
         chk16("dq_oe", 16'(e_oe[cyc]), 16'(dq_oe));
         chk16("dq_out", e_d[cyc] & lm, dq_out & lm);
      end
      // A read mask hides the beat two steps on
      if (e_oe.exists(cyc + 2)) begin
         e_oe[cyc + 2] &= ~m;
      end
      {ras_n, cas_n, we_n} = c;
      cs_n = 1'b0;
      ba = b;
      addr = a;
      dq_in = d;
      dqm = m;
      seed = lfsr(seed);
      stall = hold | seed[0];
   endtask
   task automatic idle(input int n);
      repeat (n) step(NOP, 2'h0, 13'h0, lfsr(seed), 2'h0);
   endtask
   // Drop expectations overridden by a new command
   task automatic cut(input int t);
      for (int i = t; i < t + 64; i++) begin
         if (e_oe.exists(i)) begin
            e_oe.delete(i);
            e_d.delete(i);
         end
      end
   endtask
   task automatic wr(input logic [1:0] b, input logic [8:0] st, input int n, input logic me);
      logic [8:0] c;
      logic [1:0] m;
      logic [15:0] d;
      for (int k = 0; k < n; k++) begin
         d = seed;
         c = bcol(st, k);
         m = me ? d[1:0] & d[3:2] : 2'h0;
         step((k == 0) ? CMD_WRITE : NOP, b, {4'h0, st}, d, m);
         if (k == 0) begin
            // A write ends read beats not yet strobed
            cut(cyc + g_cl);
            e_d[cyc + g_cl] = 16'h0;
            e_oe[cyc + g_cl] = 2'h0;
         end
         if (k < keep && !m[0]) mir[b][c][7:0] = d[7:0];
         if (k < keep && !m[1]) mir[b][c][15:8] = d[15:8];
      end
   endtask
   task automatic rd(input logic [1:0] b, input logic [8:0] st, input int n, input logic tail);
      step(CMD_READ, b, {4'h0, st}, 16'hzzzz, 2'h0);
      #1;
      chk16("mem_rd_row", 16'(g_row[b]), 16'(mem_rd_row));
      cut(cyc + g_cl);
      for (int k = 0; k < n; k++) begin
         e_d[cyc + g_cl + k] = mir[b][bcol(st, k)];
         e_oe[cyc + g_cl + k] = 2'h3;
      end
      if (tail) begin
         e_d[cyc + g_cl + n] = 16'h0;
         e_oe[cyc + g_cl + n] = 2'h0;
      end
   endtask
   task automatic stp();
      step(CMD_STOP, 2'h0, 13'h0, seed, 2'h0);
      cut(cyc + g_cl);
      e_d[cyc + g_cl] = 16'h0;
      e_oe[cyc + g_cl] = 2'h0;
   endtask
   // Close all banks first, then program and wait
   task automatic mrs(input logic [2:0] bl, input logic il, input logic [2:0] cl);
      g_bl = bl;
      g_il = il;
      g_cl = (cl == CL_2) ? 2 : 3;
      step(CMD_PRE, 2'h0, 13'h400, seed, 2'h0);
      idle(2);
      step(CMD_MRS, 2'h0, {6'h0, cl, il, bl}, seed, 2'h0);
      idle(2);
   endtask
   task automatic act(input logic [1:0] b);
      g_row[b] = seed[12:0];
      step(CMD_ACT, b, seed[12:0], seed, 2'h0);
      idle(2);
   endtask
   task automatic drain();
      int i;
      hold = 1'b0;
      i = 0;
      while (mem_wr_valid !== 1'b0 && i < 300) begin
         if (mem_wr_valid === 1'b1) begin
            chk16("mem_wr_row", 16'(g_row[mem_wr_bank]), 16'(mem_wr_row));
         end
         idle(1);
         i++;
      end
      chk16("mem_wr_valid", 16'h0, 16'(mem_wr_valid));
      idle(2);
   endtask

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Hang guard, far beyond the few hundred steps expected
   initial begin
      #(50 * 20000);
      fails++;
      summarize();
   end
   initial begin
      reset_n = 1'b0;
      cke = 1'b1;
      cs_n = 1'b1;
      {ras_n, cas_n, we_n} = NOP;
      ba = 2'h0;
      addr = 13'h0;
      dqm = 2'h0;
      dq_in = 16'h0;
      stall = 1'b0;
      hold = 1'b0;
      seed = 16'hc780;
      cyc = 0;
      keep = 64;
      fails = 0;
      tests_run = 0;
      for (int i = 0; i < 2048; i++) mir[i / 512][i % 512] = 16'(i) ^ 16'ha5a5;
      repeat (3) @(negedge mclk);
      chk16("dq_oe", 16'h0, 16'(dq_oe));
      chk16("write_buf_ready", 16'h1, 16'(write_buf_ready));
      reset_n = 1'b1;
      idle(1);
      // Lengths 1 to 8, both orders; lengths 1 and 4 at latency two, 2 and 8 at three
      for (int i = 0; i < 8; i++) begin
         mrs(3'(i % 4), i[2], i[0] ? CL_3 : CL_2);
         act(2'(i));
         s = seed[8:0];
         wr(2'(i), s, 1 << (i % 4), 1'b1);
         idle(1);
         drain();
         rd(2'(i), s, 1 << (i % 4), 1'b1);
         idle(8);
      end
      // Back-to-back commands and interruptions
      mrs(BL_4, 1'b0, CL_2);
      act(2'h0);
      act(2'h1);
      wr(2'h0, 9'h0, 2, 1'b0);
      wr(2'h0, 9'h8, 4, 1'b0);
      wr(2'h1, 9'h28, 2, 1'b0);
      rd(2'h1, 9'h0, 4, 1'b1);
      idle(8);
      drain();
      rd(2'h0, 9'h8, 4, 1'b0);
      rd(2'h0, 9'h0, 4, 1'b1);
      idle(8);
      rd(2'h1, 9'h28, 4, 1'b0);
      step(NOP, 2'h0, 13'h0, seed, 2'h1);
      stp();
      idle(4);
      rd(2'h1, 9'h28, 4, 1'b1);
      idle(8);
      // Write cuts a read; the controller masks the two overlap beats
      rd(2'h0, 9'h8, 4, 1'b0);
      step(NOP, 2'h0, 13'h0, seed, 2'h3);
      step(NOP, 2'h0, 13'h0, seed, 2'h3);
      wr(2'h0, 9'h10, 4, 1'b0);
      idle(2);
      drain();
      // Full page into a stalled buffer until it refuses
      mrs(BL_PAGE, 1'b0, CL_3);
      act(2'h2);
      hold = 1'b1;
      keep = 16;
      wr(2'h2, 9'h1f4, 20, 1'b0);
      stp();
      chk16("write_buf_ready", 16'h0, 16'(write_buf_ready));
      keep = 64;
      drain();
      chk16("write_buf_ready", 16'h1, 16'(write_buf_ready));
      rd(2'h2, 9'h1f4, 20, 1'b0);
      idle(20);
      stp();
      idle(6);
      // Clock enable low at the edge before: the read is ignored
      cke = 1'b0;
      idle(1);
      step(CMD_READ, 2'h2, 13'h0, seed, 2'h0);
      e_d[cyc + g_cl] = 16'h0;
      e_oe[cyc + g_cl] = 2'h0;
      cke = 1'b1;
      idle(4);
      step(CMD_PRE, 2'h0, 13'h400, seed, 2'h0);
      idle(2);
      summarize();
   end
endmodule

// >>> sdcb_fifo.sv
/*
 Write data buffer: a FIFO with valid and ready on both sides.
 Assumes one clock and an active-low asynchronous reset; the drain
 side may stall at will, and then the buffer really fills.
*/
`timescale 1ns/1ps
module sdcb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input logic mclk,
   input logic reset_n,
   input logic in_valid,
   output logic in_ready,
   input logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] store [DEPTH]; // Word storage
   logic [PTR_W-1:0] wr_ptr; // Next slot to fill
   logic [PTR_W-1:0] rd_ptr; // Oldest word
   logic [PTR_W:0] count; // Words held
   logic [PTR_W-1:0] next_wr_ptr;
   logic [PTR_W-1:0] next_rd_ptr;
   logic [PTR_W:0] next_count;
   logic push;
   logic pop;

   assign in_ready = (count != DEPTH_CNT);
   assign out_valid = (count != '0);
   assign out_data = store[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer and fill level update
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : PTR_W'(wr_ptr + 1'b1);
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : PTR_W'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
         next_count = (PTR_W+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (PTR_W+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // Storage has no reset; words are only read once counted in
   always_ff @(posedge mclk) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end
endmodule

// >>> sdcb_pkg.sv
/*
 Shared constants and types of the SDRAM command and burst logic:
 pin widths, command codes, mode register fields, reset values and
 the burst state encoding.
 Assumes every design file except the FIFO imports it whole.
*/
package sdcb_pkg;

   // Pin and storage widths
   localparam int ADDR_W = 13;
   localparam int COL_W = 9;
   localparam int BANK_W = 2;
   localparam int NUM_BANKS = 4;
   localparam int DATA_W = 16;
   localparam int MASK_W = 2;

   // Write buffer shape
   localparam int FIFO_DEPTH = 16;
   localparam int WR_WORD_W = BANK_W + ADDR_W + COL_W + MASK_W + DATA_W;

   // Command codes on {ras_n, cas_n, we_n} with cs_n low
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_READ = 3'h5;
   localparam logic [2:0] CMD_STOP = 3'h6;

   // Address bit that selects all banks on precharge
   localparam int PRE_ALL_BIT = 10;

   // Mode register field positions on the address pins
   localparam int MR_BL_LSB = 0;
   localparam int MR_BL_W = 3;
   localparam int MR_BT_BIT = 3;
   localparam int MR_CL_LSB = 4;
   localparam int MR_CL_W = 3;

   // Burst length codes
   localparam logic [2:0] BL_1 = 3'h0;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;

   // CAS latency codes
   localparam logic [2:0] CL_2 = 3'h2;
   localparam logic [2:0] CL_3 = 3'h3;

   // Mode register reset values
   localparam logic [2:0] MR_BL_RESET = BL_1;
   localparam logic MR_BT_RESET = 1'b0;
   localparam logic [2:0] MR_CL_RESET = CL_3;

   // Burst engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10
   } sdcb_state_type;

endpackage

// >>> sdcb_store_model.sv
/*
 Storage array model behind the burst engine: one-cycle synchronous
 read and a drain port that can stall or run at half rate.
 Assumes the engine's mem_ ports and a single clock; rows are not told apart.
*/
`timescale 1ns/1ps
module sdcb_store_model (
   input logic mclk,
   input logic mem_rd_en,
   input logic [sdcb_pkg::BANK_W-1:0] mem_rd_bank,
   input logic [sdcb_pkg::COL_W-1:0] mem_rd_col,
   output logic [sdcb_pkg::DATA_W-1:0] mem_rd_data,
   input logic mem_wr_valid,
   output logic mem_wr_ready,
   input logic [sdcb_pkg::BANK_W-1:0] mem_wr_bank,
   input logic [sdcb_pkg::COL_W-1:0] mem_wr_col,
   input logic [sdcb_pkg::MASK_W-1:0] mem_wr_mask,
   input logic [sdcb_pkg::DATA_W-1:0] mem_wr_data,
   input logic stall
);
   import sdcb_pkg::*;
   logic [15:0] mem [0:2047]; // Indexed by bank and column
   logic half; // Slow drain phase
   // Known start pattern, mirrored by the bench
   initial begin
      for (int i = 0; i < 2048; i++) begin
         mem[i] = 16'(i) ^ 16'ha5a5;
      end
      half = 1'b0;
      mem_rd_data = 16'h0;
   end
   // Never faster than every other cycle, so the buffer really backs up
   assign mem_wr_ready = ~stall & half;
   // Idle cycles invert the bus so stale data never looks valid
   // Plain always, since the preload block writes the same variables
   always @(posedge mclk) begin
      half <= ~half;
      mem_rd_data <= mem_rd_en ? mem[{mem_rd_bank, mem_rd_col}] : ~mem_rd_data;
      if (mem_wr_valid && mem_wr_ready) begin
         if (mem_wr_mask[0]) begin
            mem[{mem_wr_bank, mem_wr_col}][7:0] <= mem_wr_data[7:0];
         end
         if (mem_wr_mask[1]) begin
            mem[{mem_wr_bank, mem_wr_col}][15:8] <= mem_wr_data[15:8];
         end
      end
   end
endmodule
